// File: rtl/scr_pkg.sv
/*
 * Package of the system control register block: register byte addresses,
 * control field positions, reset values, action codes and cycle counts.
 * Assumes a single 250 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package scr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [31:0] SCR_ADDR_CTRL = 32'hffb00000;
    localparam logic [31:0] SCR_ADDR_STAT = 32'hffb00040;
    localparam logic [31:0] SCR_ADDR_MASK = 32'hffb00044;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int SCR_POS_ORDER = 31;
    localparam int SCR_POS_RSVD = 29;
    localparam int SCR_POS_BCLK_OFF = 28;
    localparam int SCR_POS_WDOG_EN = 24;
    localparam int SCR_POS_WDOG_ACT = 22;
    localparam int SCR_POS_WDOG_TO = 20;
    localparam int SCR_POS_MON_EN = 18;
    localparam int SCR_POS_MON_TO = 16;
    localparam int SCR_POS_USER = 15;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] SCR_RSVD_VAL = 2'h2;
    localparam logic [2:0] SCR_MASK_RST = 3'h0;
    localparam logic [1:0] SCR_STRAP_WAIT = 2'h3;

    // ----------------------------------------------------------------
    // Watchdog action codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SCR_ACT_IRQ = 2'h0;
    localparam logic [1:0] SCR_ACT_FIQ = 2'h1;
    localparam logic [1:0] SCR_ACT_RST = 2'h2;

    // ----------------------------------------------------------------
    // Status bit positions
    // ----------------------------------------------------------------
    localparam int SCR_ST_WDOG = 0;
    localparam int SCR_ST_BUSMON = 1;
    localparam int SCR_ST_USER = 2;

    // ----------------------------------------------------------------
    // Counts
    // ----------------------------------------------------------------
    localparam logic [7:0] SCR_MON_BASE = 8'h80;
    localparam int SCR_CLK_NS = 4;
    localparam int SCR_WDOG_RST_NS = 64;
    localparam logic [4:0] SCR_WDOG_RST_CYC = 5'(SCR_WDOG_RST_NS / SCR_CLK_NS);

    typedef struct packed {
        logic byte_order_sel;
        logic bus_clk_out_off;
        logic wdog_en;
        logic [1:0] wdog_action_sel;
        logic [1:0] wdog_timeout_sel;
        logic bus_mon_en;
        logic [1:0] bus_mon_timeout_sel;
        logic user_access;
    } scr_ctrl_s;

endpackage

// File: rtl/scr_top.sv
/*
 * System control register block: control register with byte order, bus clock
 * output gate, watchdog, bus monitor and user-mode register access gate,
 * plus an interrupt status/mask pair, all on an AHB-Lite slave port.
 * Assumes the crystal clock, the boot strap and the transfer acknowledge arrive
 * from pins; bus cycle and access requests come from logic on clock_i.
 */
// The AHB-Lite register port is this design's own decision.
// How it works
// - Byte order bit: 1 little endian, 0 big endian; resets from boot strap.
// - Two bits below byte order start as 10 and always read 10.
// - Bus clock off bit 1 holds bus clock pin low; resets to 0.
// - Writing 1 to watchdog enable starts the watchdog; resets to 0.
// - Once set, watchdog enable ignores writes of 0 until hardware reset.
// - Watchdog expiry gives normal interrupt, fast interrupt or reset; fourth code reserved.
// - Watchdog timeout is 2^20, 2^22, 2^24 or 2^25 crystal periods.
// - Bus monitor runs only while its enable bit is 1; resets to 0.
// - Bus monitor times each peripheral access still lacking transfer acknowledge.
// - Bus monitor expiry ends the bus cycle and aborts the owning master.
// - Bus monitor timeout is 128, 64, 32 or 16 bus clocks.
// - User bit 0 refuses unprivileged register accesses with a data abort.
// - User bit 1 accepts register accesses from every processor mode.
// - Watchdog reset is synchronous and takes effect on its release.
`timescale 1ns/100ps

module scr_top #(
    parameter int unsigned WDOG_TO_0 = 32'd1048576,
    parameter int unsigned WDOG_TO_1 = 32'd4194304,
    parameter int unsigned WDOG_TO_2 = 32'd16777216,
    parameter int unsigned WDOG_TO_3 = 32'd33554432
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic boot_order_strap_i,
    input wire logic crystal_freq_i,
    input wire logic xfer_ack_n_i,
    input wire logic bus_cycle_i,
    input wire logic reg_access_i,
    input wire logic user_mode_i,
    output logic byte_order_sel_o,
    output logic bus_clk_o,
    output logic bus_abort_o,
    output logic reg_abort_o,
    output logic fast_irq_o,
    output logic wdog_rst_o,
    output logic irq_o
);
    import scr_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic strap_s1, strap_s2, xtal_s1, xtal_s2, xtal_s3, ack_s1, ack_s2;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            xtal_s1 <= 1'b0;
            xtal_s2 <= 1'b0;
            xtal_s3 <= 1'b0;
            ack_s1 <= 1'b1;
            ack_s2 <= 1'b1;
        end else begin
            strap_s1 <= boot_order_strap_i;
            strap_s2 <= strap_s1;
            xtal_s1 <= crystal_freq_i;
            xtal_s2 <= xtal_s1;
            xtal_s3 <= xtal_s2;
            ack_s1 <= xfer_ack_n_i;
            ack_s2 <= ack_s1;
        end
    end

    logic xtal_tick;
    assign xtal_tick = xtal_s2 & ~xtal_s3;

    // ----------------------------------------------------------------
    // AHB-Lite slave and register state
    // ----------------------------------------------------------------
    scr_ctrl_s ctrl, next_ctrl;
    logic [2:0] stat, next_stat, mask, next_mask;
    logic [1:0] strap_cnt, next_strap_cnt;
    logic wr_pend, next_wr_pend;
    logic [31:0] wr_addr, next_wr_addr, hrdata, next_hrdata;
    logic [2:0] events;
    logic addr_phase;
    logic [31:0] ctrl_word;

    assign addr_phase = hsel_i & htrans_i[1] & hready_i;

    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[SCR_POS_ORDER] = ctrl.byte_order_sel;
        ctrl_word[SCR_POS_RSVD +: 2] = SCR_RSVD_VAL;
        ctrl_word[SCR_POS_BCLK_OFF] = ctrl.bus_clk_out_off;
        ctrl_word[SCR_POS_WDOG_EN] = ctrl.wdog_en;
        ctrl_word[SCR_POS_WDOG_ACT +: 2] = ctrl.wdog_action_sel;
        ctrl_word[SCR_POS_WDOG_TO +: 2] = ctrl.wdog_timeout_sel;
        ctrl_word[SCR_POS_MON_EN] = ctrl.bus_mon_en;
        ctrl_word[SCR_POS_MON_TO +: 2] = ctrl.bus_mon_timeout_sel;
        ctrl_word[SCR_POS_USER] = ctrl.user_access;
    end

    always_comb begin
        next_ctrl = ctrl;
        next_stat = stat;
        next_mask = mask;
        next_strap_cnt = strap_cnt;
        next_wr_pend = addr_phase & hwrite_i;
        next_wr_addr = addr_phase ? haddr_i : wr_addr;
        next_hrdata = hrdata;
        // Strap caught once it has crossed both synchroniser stages
        if (strap_cnt != SCR_STRAP_WAIT) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt + 2'h1 == SCR_STRAP_WAIT) begin
                next_ctrl.byte_order_sel = ~strap_s2;
            end
        end
        if (addr_phase && !hwrite_i) begin
            case (haddr_i)
                SCR_ADDR_CTRL: next_hrdata = ctrl_word;
                SCR_ADDR_STAT: begin
                    next_hrdata = {29'h0, stat};
                    next_stat = 3'h0;
                end
                SCR_ADDR_MASK: next_hrdata = {29'h0, mask};
                default: next_hrdata = 32'h0;
            endcase
        end
        if (wr_pend) begin
            case (wr_addr)
                SCR_ADDR_CTRL: begin
                    next_ctrl.byte_order_sel = hwdata_i[SCR_POS_ORDER];
                    next_ctrl.bus_clk_out_off = hwdata_i[SCR_POS_BCLK_OFF];
                    next_ctrl.wdog_en = ctrl.wdog_en | hwdata_i[SCR_POS_WDOG_EN];
                    next_ctrl.wdog_action_sel = hwdata_i[SCR_POS_WDOG_ACT +: 2];
                    next_ctrl.wdog_timeout_sel = hwdata_i[SCR_POS_WDOG_TO +: 2];
                    next_ctrl.bus_mon_en = hwdata_i[SCR_POS_MON_EN];
                    next_ctrl.bus_mon_timeout_sel = hwdata_i[SCR_POS_MON_TO +: 2];
                    next_ctrl.user_access = hwdata_i[SCR_POS_USER];
                end
                SCR_ADDR_MASK: next_mask = hwdata_i[2:0];
                default: ;
            endcase
        end
        // Set wins over the read clear
        next_stat = next_stat | events;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= '0;
            stat <= 3'h0;
            mask <= SCR_MASK_RST;
            strap_cnt <= 2'h0;
            wr_pend <= 1'b0;
            wr_addr <= 32'h0;
            hrdata <= 32'h0;
        end else begin
            ctrl <= next_ctrl;
            stat <= next_stat;
            mask <= next_mask;
            strap_cnt <= next_strap_cnt;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
        end
    end

    assign hrdata_o = hrdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // ----------------------------------------------------------------
    // Bus clock and bus monitor
    // ----------------------------------------------------------------
    logic bclk, next_bclk, bclk_out, next_bclk_out, bus_abort, next_bus_abort;
    logic [7:0] mon_cnt, next_mon_cnt, mon_limit;

    always_comb begin
        next_bclk = ~bclk;
        next_bclk_out = next_bclk & ~ctrl.bus_clk_out_off;
        mon_limit = SCR_MON_BASE >> ctrl.bus_mon_timeout_sel;
        next_mon_cnt = mon_cnt;
        next_bus_abort = 1'b0;
        if (!(ctrl.bus_mon_en && bus_cycle_i && ack_s2)) begin
            next_mon_cnt = 8'h0;
        end else if (!bclk) begin
            if (mon_cnt + 8'h1 >= mon_limit) begin
                next_mon_cnt = 8'h0;
                next_bus_abort = 1'b1;
            end else begin
                next_mon_cnt = mon_cnt + 8'h1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bclk <= 1'b0;
            bclk_out <= 1'b0;
            mon_cnt <= 8'h0;
            bus_abort <= 1'b0;
        end else begin
            bclk <= next_bclk;
            bclk_out <= next_bclk_out;
            mon_cnt <= next_mon_cnt;
            bus_abort <= next_bus_abort;
        end
    end

    assign bus_clk_o = bclk_out;
    assign bus_abort_o = bus_abort;

    // ----------------------------------------------------------------
    // User-mode register access gate
    // ----------------------------------------------------------------
    logic reg_abort, next_reg_abort;

    always_comb begin
        next_reg_abort = reg_access_i & user_mode_i & ~ctrl.user_access;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_abort <= 1'b0;
        end else begin
            reg_abort <= next_reg_abort;
        end
    end

    assign reg_abort_o = reg_abort;

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    logic [25:0] wd_cnt, next_wd_cnt, wd_limit;
    logic wd_expire, fast_irq, next_fast_irq, wd_rst, next_wd_rst;
    logic [4:0] rst_cnt, next_rst_cnt;

    always_comb begin
        case (ctrl.wdog_timeout_sel)
            2'h0: wd_limit = 26'(WDOG_TO_0);
            2'h1: wd_limit = 26'(WDOG_TO_1);
            2'h2: wd_limit = 26'(WDOG_TO_2);
            default: wd_limit = 26'(WDOG_TO_3);
        endcase
        next_wd_cnt = wd_cnt;
        wd_expire = 1'b0;
        if (ctrl.wdog_en && xtal_tick) begin
            if (wd_cnt + 26'h1 >= wd_limit) begin
                next_wd_cnt = 26'h0;
                wd_expire = 1'b1;
            end else begin
                next_wd_cnt = wd_cnt + 26'h1;
            end
        end
        next_fast_irq = wd_expire && ctrl.wdog_action_sel == SCR_ACT_FIQ;
        next_rst_cnt = rst_cnt;
        if (wd_expire && ctrl.wdog_action_sel == SCR_ACT_RST) begin
            next_rst_cnt = SCR_WDOG_RST_CYC;
        end else if (rst_cnt != 5'h0) begin
            next_rst_cnt = rst_cnt - 5'h1;
        end
        next_wd_rst = next_rst_cnt != 5'h0;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wd_cnt <= 26'h0;
            fast_irq <= 1'b0;
            rst_cnt <= 5'h0;
            wd_rst <= 1'b0;
        end else begin
            wd_cnt <= next_wd_cnt;
            fast_irq <= next_fast_irq;
            rst_cnt <= next_rst_cnt;
            wd_rst <= next_wd_rst;
        end
    end

    assign fast_irq_o = fast_irq;
    assign wdog_rst_o = wd_rst;

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    always_comb begin
        events = 3'h0;
        events[SCR_ST_WDOG] = wd_expire && ctrl.wdog_action_sel == SCR_ACT_IRQ;
        events[SCR_ST_BUSMON] = next_bus_abort;
        events[SCR_ST_USER] = next_reg_abort;
    end

    assign irq_o = |(stat & mask);
    assign byte_order_sel_o = ctrl.byte_order_sel;

endmodule // scr_top

// File: sim/scr_monitor.sv
/* Checker of scr_top port timing: bus answer, byte order, aborts, pulses.
   Bound into scr_top; one clock, asynchronous reset rst_i. */
`timescale 1ns/100ps
module scr_monitor (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic bus_cycle_i,
    input wire logic reg_access_i,
    input wire logic user_mode_i,
    input wire logic byte_order_sel_o,
    input wire logic bus_clk_o,
    input wire logic bus_abort_o,
    input wire logic reg_abort_o,
    input wire logic fast_irq_o,
    input wire logic wdog_rst_o
);
    logic [1:0] since_rst;
    logic [1:0] next_since_rst;
    // ----
    // Edges since reset, strap load done by 3
    // ----
    always_comb begin
        next_since_rst = (since_rst == 2'h3) ? since_rst : since_rst + 2'h1;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            since_rst <= 2'h0;
        end else begin
            since_rst <= next_since_rst;
        end
    end
    default clocking mon_cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not zero wait OKAY");
    a_order_by_write: assert property ((since_rst == 2'h3 && $past(since_rst) == 2'h3 && $changed(byte_order_sel_o)) |->
        $past(hsel_i && htrans_i[1] && hwrite_i, 2)) else $error("byte order changed without a write");
    a_user_gate: assert property (reg_abort_o |-> $past(reg_access_i && user_mode_i))
        else $error("register abort without user access");
    a_mon_span: assert property (bus_abort_o |->
        $past(bus_cycle_i) && $past(bus_cycle_i, 16) && $past(bus_cycle_i, 30))
        else $error("bus abort before 16 bus clocks of cycle");
    a_abort_pulse: assert property (bus_abort_o |=> !bus_abort_o)
        else $error("bus abort longer than one cycle");
    a_fiq_pulse: assert property (fast_irq_o |=> !fast_irq_o)
        else $error("fast interrupt longer than one cycle");
    a_rst_width: assert property ($rose(wdog_rst_o) |->
        wdog_rst_o [*8] ##1 wdog_rst_o [*8] ##1 !wdog_rst_o) else $error("watchdog reset not 16 cycles");
    a_bclk_half: assert property (bus_clk_o |=> !bus_clk_o)
        else $error("bus clock high two cycles");
endmodule // scr_monitor

bind scr_top scr_monitor u_mon (.clock_i, .rst_i, .hsel_i, .htrans_i, .hwrite_i, .hreadyout_o, .hresp_o,
    .bus_cycle_i, .reg_access_i, .user_mode_i, .byte_order_sel_o, .bus_clk_o, .bus_abort_o, .reg_abort_o,
    .fast_irq_o, .wdog_rst_o);

// File: sim/scr_top_tb.sv
/* Bench of scr_top: AHB-Lite master tasks, pin drive, queued checks.
   Assumes scr_pkg and the bound checker are compiled first. */
`timescale 1ns/100ps
module scr_top_tb;
    import scr_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, boot_order_strap_i = 1'b0;
    logic crystal_freq_i = 1'b0, xfer_ack_n_i = 1'b1, bus_cycle_i = 1'b0, reg_access_i = 1'b0;
    logic user_mode_i = 1'b0, smp = 1'b0, prev_clk = 1'b0, hreadyout_o, hresp_o, byte_order_sel_o;
    logic bus_clk_o, bus_abort_o, reg_abort_o, fast_irq_o, wdog_rst_o, irq_o;
    logic [1:0] htrans_i = 2'h0, sel = 2'h0, xdiv = 2'h0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, got, d;
    logic [31:0] exp_q[$];
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0, gap = 0, last_gap = 0;

    scr_top #(.WDOG_TO_0(8), .WDOG_TO_1(16), .WDOG_TO_2(32), .WDOG_TO_3(64)) DUT (
        .clock_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .boot_order_strap_i, .crystal_freq_i,
        .xfer_ack_n_i, .bus_cycle_i, .reg_access_i, .user_mode_i, .byte_order_sel_o, .bus_clk_o,
        .bus_abort_o, .reg_abort_o, .fast_irq_o, .wdog_rst_o, .irq_o);

    initial forever #2 clock_i = ~clock_i;

    // ----
    // Crystal at clock/8, event spacing, result watcher
    // ----
    always @(posedge clock_i) begin
        xdiv <= xdiv + 2'h1;
        if (xdiv == 2'h3) begin
            crystal_freq_i <= ~crystal_freq_i;
        end
        prev_clk <= bus_clk_o;
        gap <= (fast_irq_o || bus_abort_o) ? 1 : gap + 1;
        if (fast_irq_o || bus_abort_o) begin
            last_gap <= gap;
        end
        if (smp) begin
            got = (sel == 2'h0) ? hrdata_o : (sel == 2'h2) ? 32'(last_gap) : {24'h0, byte_order_sel_o,
                bus_clk_o ^ prev_clk, bus_clk_o | prev_clk, bus_abort_o, reg_abort_o, fast_irq_o, wdog_rst_o, irq_o};
            n_tests++;
            if (got !== exp_q[0]) begin
                error_cnt++;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end

    always @(posedge clock_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ----
    // Bus and check tasks, entered just after a rising edge
    // ----
    task automatic note(input logic [1:0] s, input logic [31:0] e);
        exp_q.push_back(e);
        sel <= s;
        smp <= 1'b1;
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= v;
        if (!w) note(2'h0, v);
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        smp <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic chk(input logic [1:0] s, input logic [31:0] e);
        note(s, e);
        @(posedge clock_i);
        smp <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic wait_evt(input int n);
        repeat (n) begin
            @(posedge clock_i);
            while (!(fast_irq_o || bus_abort_o)) @(posedge clock_i);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h0c8de6e5));
        boot_order_strap_i = 1'($urandom());
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        xfer(1'b0, SCR_ADDR_CTRL, {~boot_order_strap_i, SCR_RSVD_VAL, 29'h0});
        xfer(1'b0, SCR_ADDR_MASK, 32'h0);
        xfer(1'b0, SCR_ADDR_CTRL + 32'h8, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom() & 32'h90f78000 | 32'h20000000;
            d[28] = i[0];
            xfer(1'b1, SCR_ADDR_CTRL, d);
            xfer(1'b0, SCR_ADDR_CTRL, d & 32'h90f78000 | {1'b0, SCR_RSVD_VAL, 29'h0});
            chk(2'h1, {24'h0, d[31], {2{~d[28]}}, 5'h0});
        end
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, SCR_ADDR_CTRL, 32'(i[1]) << SCR_POS_USER);
            reg_access_i <= 1'b1;
            user_mode_i <= i[0];
            @(posedge clock_i);
            reg_access_i <= 1'b0;
            chk(2'h1, {24'h0, 3'h3, 1'b0, i[0] & ~i[1], 3'h0});
        end
        xfer(1'b1, SCR_ADDR_MASK, 32'h4);
        chk(2'h1, 32'h61);
        xfer(1'b0, SCR_ADDR_STAT, 32'h4);
        chk(2'h1, 32'h60);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, SCR_ADDR_CTRL, 32'h01400000 | (32'(i) << SCR_POS_WDOG_TO));
            wait_evt(2);
            chk(2'h2, 32'd64 << i);
        end
        xfer(1'b1, SCR_ADDR_CTRL, 32'h0);
        xfer(1'b0, SCR_ADDR_CTRL, 32'h41000000);
        repeat (100) @(posedge clock_i);
        xfer(1'b0, SCR_ADDR_STAT, 32'h1);
        xfer(1'b1, SCR_ADDR_CTRL, 32'h00800000);
        while (!wdog_rst_o) @(posedge clock_i);
        chk(2'h1, 32'h62);
        rst_i <= 1'b1;
        boot_order_strap_i <= ~boot_order_strap_i;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        xfer(1'b0, SCR_ADDR_CTRL, {~boot_order_strap_i, SCR_RSVD_VAL, 29'h0});
        bus_cycle_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, SCR_ADDR_CTRL, 32'h00040000 | (32'(i) << SCR_POS_MON_TO));
            wait_evt(2);
            chk(2'h2, 32'd256 >> i);
        end
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, SCR_ADDR_CTRL, 32'(i) << SCR_POS_MON_EN);
            xfer_ack_n_i <= ~i[0];
            repeat (8) @(posedge clock_i);
            xfer(1'b0, SCR_ADDR_STAT, i ? 32'h0 : 32'h2);
            repeat (300) @(posedge clock_i);
            xfer(1'b0, SCR_ADDR_STAT, 32'h0);
        end
        wrap_up();
    end
endmodule // scr_top_tb
